// File: hdl/etc_pkg.sv
// Package for the enclave tracking check block: leaf codes, result codes,
// page types, fault kinds and flag positions.
// Assumes one 25 MHz system clock domain; no software-visible registers.
package etc_pkg;
  localparam logic [7:0]  LEAF_PLAIN       = 8'h0c;
  localparam logic [7:0]  LEAF_THREADSAFE  = 8'h11;
  localparam int          FEAT_BIT_POS     = 6;
  localparam logic [7:0]  RC_OK            = 8'h00;
  localparam logic [7:0]  RC_PAGE_CONFLICT = 8'h07;
  localparam logic [7:0]  RC_PAGE_INVALID  = 8'h06;
  localparam logic [7:0]  RC_PREV_TRK_INC  = 8'h11;
  localparam logic [7:0]  RC_TRACK_NOT_REQ = 8'h1b;
  localparam logic [11:0] PAGE_OFS_MASK    = 12'hfff;
  localparam int          FLAG_POS_CF      = 0;
  localparam int          FLAG_POS_PF      = 2;
  localparam int          FLAG_POS_AF      = 4;
  localparam int          FLAG_POS_ZF      = 6;
  localparam int          FLAG_POS_SF      = 7;
  localparam int          FLAG_POS_OF      = 11;
  localparam logic [1:0]  QUAL_RES_CONFLICT = 2'h1;
  localparam logic [1:0]  QUAL_REF_CONFLICT = 2'h2;
  localparam logic [15:0] GP_ERR_ZERO      = 16'h0000;

  typedef enum logic [2:0] {
    ETC_PT_REG, ETC_PT_TCS, ETC_PT_TRIM, ETC_PT_SS_FIRST,
    ETC_PT_SS_REST, ETC_CONTROL_PAGE_TYPE, ETC_PT_VA, ETC_PT_OTHER
  } etc_ptype_e;

  typedef enum logic [1:0] {
    ETC_OUT_RESULT, ETC_OUT_GP, ETC_OUT_PF, ETC_OUT_VMEXIT
  } etc_outcome_e;
endpackage

// File: hdl/etc_check_cmp.sv
// Address checks for one operand: alignment, protected-memory range,
// canonical form and segment limit. Registered, one cycle latency.
// Assumes inputs held stable for the cycle they are sampled.
`timescale 1ns/10ps
`default_nettype none
module etc_check_cmp (
  input  wire logic        clk_sys,     // System clock
  input  wire logic        rst,         // Sync reset, active high
  input  wire logic [63:0] addr,        // Operand effective address
  input  wire logic [63:0] prm_base,    // Protected memory base
  input  wire logic [63:0] prm_limit,   // Protected memory last byte
  input  wire logic [31:0] seg_limit,   // Data segment limit
  input  wire logic        mode64,      // 64-bit mode
  output logic             misaligned,  // Not 4KB aligned
  output logic             out_of_prm,  // Outside protected memory
  output logic             noncanon,    // Non-canonical (64-bit)
  output logic             over_limit   // Beyond segment limit
);
  logic canon_ok;
  assign canon_ok = (addr[63:47] == '0) || (addr[63:47] == '1);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      misaligned <= 1'b0;
      out_of_prm <= 1'b0;
      noncanon   <= 1'b0;
      over_limit <= 1'b0;
    end else begin
      misaligned <= (addr[11:0] & etc_pkg::PAGE_OFS_MASK) != 12'h000;
      out_of_prm <= (addr < prm_base) || (addr > prm_limit);
      noncanon   <= mode64 && !canon_ok;
      // Limit check covers the full page the leaf touches
      over_limit <= !mode64 &&
                    ((addr[31:0] | 32'h00000fff) > seg_limit);
    end
  end
endmodule
`default_nettype wire

// File: hdl/etc_track_check.sv
// Functional notes
// R1: Unaligned operand gives general-protection fault zero
// R2: Operand outside protected memory gives page fault
// R3: Plain tracking conflict: guest exit or fault
// R4: Plain, invalid map entry gives page fault
// R5: Plain, non-control page type gives page fault
// R6: Tracking busy: zero flag, incomplete code
// R7: Plain success code zero, failure sets zero
// R8: Result paths clear carry parity aux overflow sign
// R9: Only privilege level zero may execute
// R10: Protected mode segment limit violation faults
// R11: 64-bit non-canonical address faults with zero
// R12: Thread-safe variant is leaf 11h, feature bit
// R13: Thread-safe variant never faults on sharing
// R14: Thread-safe codes: 0 ok, 7 conflict, 6 invalid
// R15: Thread-safe codes: 17 incomplete, 27 not needed
// R16: Success arms tracking for the control page
// R17: Thread-safe locates control page via owner ref
// R18: Thread-safe carry set only for not-needed type
// R19: First failing check alone decides outcome
//
// Tracking leaf check and result unit. A request pulse carries the leaf
// code, operand and the page-map lookup already done by the core.
// Assumes request inputs are valid in the cycle of the pulse only.
`timescale 1ns/10ps
`default_nettype none
module etc_track_check (
  input  wire logic              clk_sys,        // 25 MHz clock
  input  wire logic              rst,            // Sync reset, high
  input  wire logic              req,            // Leaf request pulse
  input  wire logic [7:0]        leaf,           // Accumulator leaf code
  input  wire logic [63:0]       operand_addr,   // Operand address reg
  input  wire logic [1:0]        cpl,            // Current privilege
  input  wire logic              mode64,         // 64-bit mode
  input  wire logic [31:0]       seg_limit,      // Data segment limit
  input  wire logic [63:0]       prm_base,       // Protected mem base
  input  wire logic [63:0]       prm_limit,      // Protected mem last
  input  wire logic              guest_ext,      // Guest, ext enabled
  input  wire logic              pme_valid,      // Map entry valid
  input  wire etc_pkg::etc_ptype_e pme_type,     // Map entry page type
  input  wire logic              page_busy,      // Page being modified
  input  wire logic              track_in_use,   // Tracking facility busy
  input  wire logic              tracking_nz,    // Control page tracking
  input  wire logic [63:0]       owner_ref,      // Owning control page
  output logic                   done,           // Outcome valid pulse
  output etc_pkg::etc_outcome_e  outcome,        // Outcome kind
  output logic [15:0]            fault_err,      // Fault error code
  output logic [63:0]            fault_addr,     // Page fault address
  output logic [1:0]             exit_qual,      // Exit qualification
  output logic [63:0]            result,         // Result register
  output logic [11:0]            flags,          // Flag register image
  output logic                   track_start,    // Arm tracking pulse
  output logic [63:0]            track_page,     // Control page armed
  output logic                   feat_threadsafe // Feature bit, EAX[6]
);
  //////////////////////////////////////////////////////////////////////
  // Stage 1: request capture beside the registered address checks
  //////////////////////////////////////////////////////////////////////
  logic                  leaf_known;  // Leaf belongs to this unit
  logic                  pend;        // Outcome due next cycle
  logic                  is_plain;    // Captured leaf is the plain one
  logic                  cpl_nz;      // Captured privilege not zero
  logic                  guest;       // Captured guest with extension
  logic                  valid_q;     // Captured map entry valid
  etc_pkg::etc_ptype_e   type_q;      // Captured page type
  logic                  busy_q;      // Captured page busy
  logic                  in_use_q;    // Captured facility busy
  logic                  trk_nz_q;    // Captured tracking busy
  logic [63:0]           addr_q;      // Captured operand
  logic [63:0]           owner_q;     // Captured owning control page
  logic                  misaligned;  // From address checks
  logic                  out_of_prm;  // From address checks
  logic                  noncanon;    // From address checks
  logic                  over_limit;  // From address checks

  // Other leaf codes belong to other units and get no outcome here
  assign leaf_known = (leaf == etc_pkg::LEAF_PLAIN) ||
                      (leaf == etc_pkg::LEAF_THREADSAFE); // [R12]

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend <= 1'b0;
    end else begin
      pend <= req && leaf_known; // [R19]
    end
  end

  // Operands are latched once; the core may move on after the pulse
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      is_plain <= 1'b0;
      cpl_nz   <= 1'b0;
      guest    <= 1'b0;
      valid_q  <= 1'b0;
      type_q   <= etc_pkg::ETC_PT_REG;
      busy_q   <= 1'b0;
      in_use_q <= 1'b0;
      trk_nz_q <= 1'b0;
      addr_q   <= 64'h0;
      owner_q  <= 64'h0;
    end else if (req) begin
      is_plain <= leaf == etc_pkg::LEAF_PLAIN;
      cpl_nz   <= cpl != 2'h0; // [R9]
      guest    <= guest_ext;
      valid_q  <= pme_valid;
      type_q   <= pme_type;
      busy_q   <= page_busy;
      in_use_q <= track_in_use;
      trk_nz_q <= tracking_nz;
      addr_q   <= operand_addr;
      owner_q  <= owner_ref;
    end
  end

  // Address checks run every cycle; only the request cycle is used
  etc_check_cmp u_etc_check_cmp (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .addr       (operand_addr),
    .prm_base   (prm_base),
    .prm_limit  (prm_limit),
    .seg_limit  (seg_limit),
    .mode64     (mode64),
    .misaligned (misaligned),
    .out_of_prm (out_of_prm),
    .noncanon   (noncanon),
    .over_limit (over_limit)
  );

  //////////////////////////////////////////////////////////////////////
  // Stage 2: ordered checks, the first failure decides
  //////////////////////////////////////////////////////////////////////
  etc_pkg::etc_outcome_e next_outcome;
  logic [15:0]           next_fault_err;
  logic [63:0]           next_fault_addr;
  logic [1:0]            next_exit_qual;
  logic [63:0]           next_result;
  logic                  next_zf;
  logic                  next_cf;
  logic                  next_track;
  logic [63:0]           next_page;
  logic [11:0]           next_flags;
  logic                  ctl_by_owner;
  logic                  ctl_direct;

  always_comb begin
    ctl_by_owner = 1'b0;
    ctl_direct   = 1'b0;
    unique case (type_q)
      etc_pkg::ETC_PT_REG,
      etc_pkg::ETC_PT_TCS,
      etc_pkg::ETC_PT_TRIM,
      etc_pkg::ETC_PT_SS_FIRST,
      etc_pkg::ETC_PT_SS_REST: begin
        ctl_by_owner = 1'b1; // [R17]
      end
      etc_pkg::ETC_CONTROL_PAGE_TYPE: begin
        ctl_direct = 1'b1; // [R17]
      end
      default: ctl_direct = 1'b0;
    endcase
  end

  always_comb begin
    next_outcome    = etc_pkg::ETC_OUT_RESULT;
    next_fault_err  = etc_pkg::GP_ERR_ZERO; // [R11]
    next_fault_addr = addr_q; // [R2]
    next_exit_qual  = 2'h0;
    next_result     = {56'h0, etc_pkg::RC_OK};
    next_zf         = 1'b0;
    next_cf         = 1'b0;
    next_track      = 1'b0;
    next_page       = addr_q;
    // Order is part of the contract: one outcome per leaf
    if (cpl_nz) begin
      next_outcome = etc_pkg::ETC_OUT_GP; // [R9][R19]
    end else if (noncanon) begin
      next_outcome = etc_pkg::ETC_OUT_GP; // [R11]
    end else if (over_limit) begin
      next_outcome = etc_pkg::ETC_OUT_GP; // [R10]
    end else if (misaligned) begin
      next_outcome = etc_pkg::ETC_OUT_GP; // [R1]
    end else if (out_of_prm) begin
      next_outcome = etc_pkg::ETC_OUT_PF; // [R2]
    end else if (is_plain) begin
      if (in_use_q && guest) begin
        next_outcome    = etc_pkg::ETC_OUT_VMEXIT; // [R3]
        next_exit_qual  = etc_pkg::QUAL_RES_CONFLICT;
        next_fault_addr = 64'h0;
      end else if (in_use_q) begin
        next_outcome = etc_pkg::ETC_OUT_GP; // [R3]
      end else if (!valid_q) begin
        next_outcome = etc_pkg::ETC_OUT_PF; // [R4]
      end else if (type_q != etc_pkg::ETC_CONTROL_PAGE_TYPE) begin
        next_outcome = etc_pkg::ETC_OUT_PF; // [R5]
      end else if (trk_nz_q && guest) begin
        next_outcome    = etc_pkg::ETC_OUT_VMEXIT; // [R6]
        next_exit_qual  = etc_pkg::QUAL_REF_CONFLICT;
        next_fault_addr = 64'h0;
      end else if (trk_nz_q) begin
        next_result = {56'h0, etc_pkg::RC_PREV_TRK_INC}; // [R6]
        next_zf     = 1'b1; // [R7]
      end else begin
        next_track  = 1'b1; // [R7][R16]
      end
    end else begin
      // Thread-safe leaf: sharing yields codes, or a guest exit when guest with facility or tracking busy, never a fault
      if (busy_q) begin
        next_result = {56'h0, etc_pkg::RC_PAGE_CONFLICT}; // [R14]
        next_zf     = 1'b1;
      end else if (!valid_q) begin
        next_result = {56'h0, etc_pkg::RC_PAGE_INVALID}; // [R14]
        next_zf     = 1'b1;
      end else if (!ctl_by_owner && !ctl_direct) begin
        next_result = {56'h0, etc_pkg::RC_TRACK_NOT_REQ}; // [R15]
        next_cf     = 1'b1; // [R18]
      end else if (in_use_q && guest) begin
        next_outcome    = etc_pkg::ETC_OUT_VMEXIT;
        next_exit_qual  = etc_pkg::QUAL_RES_CONFLICT;
        next_fault_addr = 64'h0;
      end else if (in_use_q) begin
        next_result = {56'h0, etc_pkg::RC_PAGE_CONFLICT}; // [R13]
        next_zf     = 1'b1;
      end else if (trk_nz_q && guest) begin
        next_outcome    = etc_pkg::ETC_OUT_VMEXIT;
        next_exit_qual  = etc_pkg::QUAL_REF_CONFLICT;
        next_fault_addr = 64'h0;
      end else if (trk_nz_q) begin
        next_result = {56'h0, etc_pkg::RC_PREV_TRK_INC}; // [R15]
        next_zf     = 1'b1;
      end else begin
        next_track  = 1'b1; // [R16]
        next_page   = ctl_by_owner ? owner_q : addr_q; // [R17]
      end
    end
  end
  // Only the listed flags move; the rest of the image is kept
  always_comb begin
    next_flags = flags;
    next_flags[etc_pkg::FLAG_POS_PF] = 1'b0; // [R8]
    next_flags[etc_pkg::FLAG_POS_AF] = 1'b0;
    next_flags[etc_pkg::FLAG_POS_SF] = 1'b0;
    next_flags[etc_pkg::FLAG_POS_OF] = 1'b0;
    next_flags[etc_pkg::FLAG_POS_ZF] = next_zf; // [R7]
    next_flags[etc_pkg::FLAG_POS_CF] = next_cf; // [R8][R18]
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done        <= 1'b0;
      track_start <= 1'b0;
    end else begin
      done        <= pend; // [R19]
      track_start <= pend && next_track; // [R16]
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      outcome    <= etc_pkg::ETC_OUT_RESULT;
      fault_err  <= etc_pkg::GP_ERR_ZERO;
      fault_addr <= 64'h0;
      exit_qual  <= 2'h0;
    end else if (pend) begin
      outcome    <= next_outcome;
      fault_err  <= next_fault_err; // [R1]
      fault_addr <= next_fault_addr;
      exit_qual  <= next_exit_qual;
    end
  end

  // A fault leaves the result and flag image as they were
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result <= 64'h0;
      flags  <= 12'h000;
    end else if (pend && next_outcome == etc_pkg::ETC_OUT_RESULT) begin
      result <= next_result;
      flags  <= next_flags;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      track_page <= 64'h0;
    end else if (pend && next_track) begin
      track_page <= next_page;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      feat_threadsafe <= 1'b0;
    end else begin
      feat_threadsafe <= 1'b1; // [R12]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Assertions and cover points
  //////////////////////////////////////////////////////////////////////
  property p_done;
    @(posedge clk_sys) disable iff (rst) (req && leaf_known) |-> ##2 done;
  endproperty
  a_done: assert property (p_done) else $error("No outcome"); // [R19]
  property p_gp;
    @(posedge clk_sys) disable iff (rst)
      done && outcome == etc_pkg::ETC_OUT_GP |-> fault_err == '0;
  endproperty
  a_gp: assert property (p_gp) else $error("Fault code not zero"); // [R1]
  property p_flg;
    @(posedge clk_sys) disable iff (rst)
      done && outcome == etc_pkg::ETC_OUT_RESULT |-> (flags & 12'h894) == '0;
  endproperty
  a_flg: assert property (p_flg) else $error("Flags left set"); // [R8]
  property p_cf;
    @(posedge clk_sys) disable iff (rst)
      done && outcome == etc_pkg::ETC_OUT_RESULT |->
      flags[0] == (result[7:0] == etc_pkg::RC_TRACK_NOT_REQ);
  endproperty
  a_cf: assert property (p_cf) else $error("Carry flag wrong"); // [R18]
  property p_trk;
    @(posedge clk_sys) disable iff (rst)
      track_start |-> done && result == '0;
  endproperty
  a_trk: assert property (p_trk) else $error("Tracking armed"); // [R16]
  property p_cpl;
    @(posedge clk_sys) disable iff (rst)
      pend && cpl_nz |=> done && outcome == etc_pkg::ETC_OUT_GP;
  endproperty
  a_cpl: assert property (p_cpl) else $error("Privilege not gated"); // [R9]
  c_plain_ok: cover property (@(posedge clk_sys) track_start && is_plain);
  c_vm_exit: cover property (@(posedge clk_sys) done && exit_qual != 2'h0);
  c_no_track: cover property (@(posedge clk_sys) done && flags[0]);
endmodule
`default_nettype wire

// File: test/etc_sw_model.sv
// Software side: issues one leaf of case k per go pulse.
// Assumes the unit samples req on the rising edge.
`timescale 1ns/10ps
`default_nettype none
module etc_sw_model (
  input  wire logic           clk_sys, // Clock
  input  wire logic           go,      // Issue
  input  wire logic [2:0]     k,       // Case
  output logic                req,     // Request
  output logic [7:0]          leaf,    // Leaf code
  output logic [63:0]         addr,    // Operand
  output logic                vld,     // Entry valid
  output etc_pkg::etc_ptype_e ptype,   // Page type
  output logic                busy,    // Page busy
  output logic                nz       // Tracking busy
);
  always_ff @(posedge clk_sys) begin
    req <= go;
    if (go) begin
      leaf <= k > 3'h2 ? etc_pkg::LEAF_THREADSAFE : etc_pkg::LEAF_PLAIN;
      addr <= 64'h100000 + {44'h0, 8'($urandom), 12'h000}
        + {63'h0, k == 3'h1} + (k == 3'h7 ? 64'h1000000 : 64'h0);
      vld <= k != 3'h4;
      ptype <= k == 3'h5 ? etc_pkg::ETC_PT_VA : k == 3'h6
        ? etc_pkg::ETC_PT_REG : etc_pkg::ETC_CONTROL_PAGE_TYPE;
      busy <= k == 3'h3;
      nz <= k == 3'h2;
    end
  end
endmodule
`default_nettype wire

// File: test/test_enclave_tracking_check.sv
// Bench: random order of eight leaf cases, expected outcomes queued.
`timescale 1ns/10ps
`default_nettype none
module test_enclave_tracking_check;
  logic clk_sys = 1'b0, rst = 1'b1, go = 1'b0, done, vld, busy, nz, req, r;
  logic [2:0] k = 3'h0;
  logic [1:0] cpl = 2'h0;
  logic guest = 1'b0, in_use = 1'b0;
  logic [7:0] leaf;
  logic [63:0] addr, result, fault_addr, owner = 64'h0;
  logic [15:0] fault_err;
  logic [11:0] flags;
  etc_pkg::etc_ptype_e ptype;
  etc_pkg::etc_outcome_e outcome;
  logic [12:0] q[$], obs, e, xp, tp, tbl[8] = '{13'h0, 13'h800, 13'h8c, 13'h3c,
    13'h34, 13'hda, 13'h0, 13'h1000};
  int mismatches = 0, checks_done = 0, cyc = 0, n;
  always #20 clk_sys = ~clk_sys;
  etc_sw_model u_etc_sw_model (.clk_sys, .go, .k, .req, .leaf, .addr,
    .vld, .ptype, .busy, .nz);
  etc_track_check u_etc_track_check (.clk_sys, .rst, .req, .leaf,
    .operand_addr(addr), .cpl(cpl), .mode64(1'b1), .seg_limit(32'h0),
    .prm_base(64'h100000), .prm_limit(64'h1fffff), .guest_ext(guest),
    .pme_valid(vld), .pme_type(ptype), .page_busy(busy),
    .track_in_use(in_use), .tracking_nz(nz), .owner_ref(owner), .done,
    .outcome, .fault_err, .fault_addr, .exit_qual(), .result, .flags,
    .track_start, .track_page, .feat_threadsafe);
  logic track_start, feat_threadsafe;
  logic [63:0] track_page;
  task automatic run_case(input int c, input logic [12:0] exp);
    @(posedge clk_sys);
    k <= 3'(c);
    go <= 1'b1;
    owner <= {20'h0, $urandom, 12'h000};
    q.push_back(exp);
    @(posedge clk_sys);
    go <= 1'b0;
    for (int i = 0; i < 50 && q.size() > 0; i++) @(posedge clk_sys);
  endtask
  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0 && q.size() == 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [12:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      end_sim();
    end
    r = outcome === etc_pkg::ETC_OUT_RESULT;
    obs = {outcome, r ? result[7:0] : outcome === etc_pkg::ETC_OUT_GP
      ? fault_err[7:0] : fault_addr[7:0], r & flags[6], r & flags[0],
      r & (flags[2] | flags[4] | flags[7] | flags[11])};
    if (done === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      xp = {e == 13'h0, 12'h000};
      if (e == 13'h0)
        xp[11:0] = leaf == etc_pkg::LEAF_PLAIN ? addr[23:12] : owner[23:12];
      tp = {track_start, track_start ? track_page[23:12] : 12'h000};
      check(obs, e);
      check(tp, xp);
      check(13'(feat_threadsafe), 13'h1);
    end
  end
  initial begin
    void'($urandom(9815));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (32) begin
      n = $urandom % 8;
      run_case(n, tbl[n]);
    end
    cpl <= 2'h3;
    run_case(0, 13'h800);
    cpl <= 2'h0;
    guest <= 1'b1;
    run_case(2, 13'h1800);
    in_use <= 1'b1;
    run_case(0, 13'h1800);
    guest <= 1'b0;
    run_case(0, 13'h800);
    run_case(6, 13'h3c);
    in_use <= 1'b0;
    end_sim();
  end
endmodule
`default_nettype wire
